// ### core/drive_cfg_pkg.sv
// package: object indices, subindices, field positions and reset values of the drive configuration bank
package drive_cfg_pkg;

  // ------------------------------------------------------------
  // object indices and subindices
  // ------------------------------------------------------------
  localparam logic [15:0] IDX_DRIVE_FLAGS   = 16'h3212;
  localparam logic [15:0] IDX_ANALOG_VALUES = 16'h3220;
  localparam logic [15:0] IDX_ANALOG_MODE   = 16'h3221;
  localparam logic [15:0] IDX_ROTARY        = 16'h3225;

  localparam logic [7:0]  SUB_COUNT         = 8'h00;
  localparam logic [7:0]  SUB_FLAGS_RSVD    = 8'h01;
  localparam logic [7:0]  SUB_FIELD_INV     = 8'h02;
  localparam logic [7:0]  SUB_KEEP_GAINS    = 8'h03;
  localparam logic [7:0]  SUB_INPUT_ONE     = 8'h01;
  localparam logic [7:0]  SUB_INPUT_TWO     = 8'h02;
  localparam logic [7:0]  SUB_ROTARY        = 8'h01;

  // highest subindex reported by each array object
  localparam logic [7:0]  FLAGS_SUB_MAX     = 8'h03;
  localparam logic [7:0]  ANALOG_SUB_MAX    = 8'h02;
  localparam logic [7:0]  ROTARY_SUB_MAX    = 8'h01;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int          MODE_BIT_ONE      = 0;
  localparam int          MODE_BIT_TWO      = 1;
  localparam logic [31:0] MODE_WRITE_MASK   = 32'h0000_0003;
  localparam logic [31:0] MODE_RESET        = 32'h0000_0000;
  localparam logic [7:0]  FLAG_RESET        = 8'h00;
  localparam logic [15:0] VALUE_RESET       = 16'h0000;

  // signed flag encodings
  localparam logic [7:0]  FIELD_DEFAULT     = 8'h00;
  localparam logic [7:0]  FIELD_POSITIVE    = 8'h01;
  localparam logic [7:0]  FIELD_NEGATIVE    = 8'hFF;
  localparam logic [7:0]  GAINS_KEEP        = 8'h01;

  // scaling: full 1024 digits = 10 V or 20 mA
  localparam int          FULL_DIGITS       = 1024;
  localparam int          FULL_MILLIVOLT    = 10000;
  localparam int          FULL_MICROAMP     = 20000;

  // field direction selection towards the commutation logic
  typedef enum logic [2:0]
  {
    DIR_FIRMWARE = 3'b001,
    DIR_POSITIVE = 3'b010,
    DIR_NEGATIVE = 3'b100
  } field_dir_e;

endpackage : drive_cfg_pkg

// ### core/obj_access_if.sv
// interface: object access bus between the bank decoder and its storage leaves
`timescale 1ns/100ps
interface obj_access_if;
  logic [15:0] index;
  logic [7:0]  subindex;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;

  modport master
  (
    output index,
    output subindex,
    output wr,
    output wdata,
    input  rdata,
    input  hit
  );

  modport leaf
  (
    input  index,
    input  subindex,
    input  wr,
    input  wdata,
    output rdata,
    output hit
  );
endinterface : obj_access_if

// ### core/drive_flag_bank.sv
// module: drive flag entries with restart-latched field inversion
`timescale 1ns/100ps
module drive_flag_bank
(
  input  wire logic     clk,
  input  wire logic     rst,
  obj_access_if.leaf    bus,
  output logic [7:0]    field_inv_active,
  output logic [7:0]    keep_gains
);

  logic [7:0] flags_reserved;
  // savable entry: power-up value zero, kept through a restart
  logic [7:0] field_inv_stored = drive_cfg_pkg::FLAG_RESET;
  logic [7:0] next_flags_reserved;
  logic [7:0] next_field_inv_stored;
  logic [7:0] next_keep_gains;
  logic       restart_pending;
  logic       next_restart_pending;

  function automatic logic sub_sel(input logic [7:0] s);
    sub_sel = (bus.index == drive_cfg_pkg::IDX_DRIVE_FLAGS) && (bus.subindex == s);
  endfunction : sub_sel

  always_comb
  begin
    next_flags_reserved   = flags_reserved;
    next_field_inv_stored = field_inv_stored;
    next_keep_gains       = keep_gains;
    next_restart_pending  = 1'b0;
    if (bus.wr && sub_sel(drive_cfg_pkg::SUB_FLAGS_RSVD))
    begin
      next_flags_reserved = bus.wdata[7:0];
    end
    if (bus.wr && sub_sel(drive_cfg_pkg::SUB_FIELD_INV))
    begin
      next_field_inv_stored = bus.wdata[7:0];
    end
    if (bus.wr && sub_sel(drive_cfg_pkg::SUB_KEEP_GAINS))
    begin
      next_keep_gains = bus.wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags_reserved   <= drive_cfg_pkg::FLAG_RESET;
      keep_gains       <= drive_cfg_pkg::FLAG_RESET;
      restart_pending  <= 1'b1;
    end
    else
    begin
      flags_reserved   <= next_flags_reserved;
      keep_gains       <= next_keep_gains;
      restart_pending  <= next_restart_pending;
    end
  end

  // not cleared by restart, else a new override could never take effect
  always_ff @(posedge clk)
  begin
    field_inv_stored <= next_field_inv_stored;
  end

  // active value taken once, in the first cycle after restart
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      field_inv_active <= drive_cfg_pkg::FLAG_RESET;
    end
    else if (restart_pending)
    begin
      field_inv_active <= field_inv_stored;
    end
  end

  always_comb
  begin
    bus.hit   = 1'b1;
    bus.rdata = 32'h0000_0000;
    if (bus.index != drive_cfg_pkg::IDX_DRIVE_FLAGS)
    begin
      bus.hit = 1'b0;
    end
    else
    begin
      case (bus.subindex)
        drive_cfg_pkg::SUB_COUNT:      bus.rdata = {24'h000000, drive_cfg_pkg::FLAGS_SUB_MAX};
        drive_cfg_pkg::SUB_FLAGS_RSVD: bus.rdata = {{24{flags_reserved[7]}}, flags_reserved};
        drive_cfg_pkg::SUB_FIELD_INV:  bus.rdata = {{24{field_inv_stored[7]}}, field_inv_stored};
        drive_cfg_pkg::SUB_KEEP_GAINS: bus.rdata = {{24{keep_gains[7]}}, keep_gains};
        default:                       bus.hit   = 1'b0;
      endcase
    end
  end

  field_hold_a: assert property (@(posedge clk) disable iff (rst)
    !restart_pending |=> $stable(field_inv_active))
    else $error("field inversion changed without restart");

endmodule : drive_flag_bank

// ### core/analog_input_bank.sv
// module: analog readings, input mode word and rotary switch entry
`timescale 1ns/100ps
module analog_input_bank
(
  input  wire logic        clk,
  input  wire logic        rst,
  obj_access_if.leaf       bus,
  input  wire logic [15:0] sample_one,
  input  wire logic [15:0] sample_two,
  input  wire logic        sample_valid,
  input  wire logic [15:0] rotary_pins,
  output logic [1:0]       current_select
);

  logic [31:0] mode_word;
  logic [31:0] next_mode_word;
  logic [15:0] value_one;
  logic [15:0] value_two;
  logic [15:0] next_value_one;
  logic [15:0] next_value_two;
  logic [15:0] rotary_value;
  logic [15:0] next_rotary_value;
  logic        rotary_taken;
  logic        next_rotary_taken;

  always_comb
  begin
    next_mode_word    = mode_word;
    next_value_one    = value_one;
    next_value_two    = value_two;
    next_rotary_value = rotary_value;
    next_rotary_taken = 1'b1;
    if (bus.wr && bus.index == drive_cfg_pkg::IDX_ANALOG_MODE && bus.subindex == drive_cfg_pkg::SUB_COUNT)
    begin
      next_mode_word = bus.wdata & drive_cfg_pkg::MODE_WRITE_MASK;
    end
    if (sample_valid)
    begin
      next_value_one = sample_one;
      next_value_two = sample_two;
    end
    if (!rotary_taken)
    begin
      next_rotary_value = rotary_pins;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_word    <= drive_cfg_pkg::MODE_RESET;
      value_one    <= drive_cfg_pkg::VALUE_RESET;
      value_two    <= drive_cfg_pkg::VALUE_RESET;
      rotary_value <= drive_cfg_pkg::VALUE_RESET;
      rotary_taken <= 1'b0;
    end
    else
    begin
      mode_word    <= next_mode_word;
      value_one    <= next_value_one;
      value_two    <= next_value_two;
      rotary_value <= next_rotary_value;
      rotary_taken <= next_rotary_taken;
    end
  end

  // one bit per input: 0 voltage, 1 current
  assign current_select = {mode_word[drive_cfg_pkg::MODE_BIT_TWO], mode_word[drive_cfg_pkg::MODE_BIT_ONE]};

  always_comb
  begin
    bus.hit   = 1'b1;
    bus.rdata = 32'h0000_0000;
    case (bus.index)
      drive_cfg_pkg::IDX_ANALOG_VALUES:
      begin
        case (bus.subindex)
          drive_cfg_pkg::SUB_COUNT:     bus.rdata = {24'h000000, drive_cfg_pkg::ANALOG_SUB_MAX};
          drive_cfg_pkg::SUB_INPUT_ONE: bus.rdata = {{16{value_one[15]}}, value_one};
          drive_cfg_pkg::SUB_INPUT_TWO: bus.rdata = {{16{value_two[15]}}, value_two};
          default:                      bus.hit   = 1'b0;
        endcase
      end
      drive_cfg_pkg::IDX_ANALOG_MODE:
      begin
        bus.hit   = (bus.subindex == drive_cfg_pkg::SUB_COUNT);
        bus.rdata = mode_word;
      end
      drive_cfg_pkg::IDX_ROTARY:
      begin
        case (bus.subindex)
          drive_cfg_pkg::SUB_COUNT:  bus.rdata = {24'h000000, drive_cfg_pkg::ROTARY_SUB_MAX};
          drive_cfg_pkg::SUB_ROTARY: bus.rdata = {16'h0000, rotary_value};
          default:                   bus.hit   = 1'b0;
        endcase
      end
      default:
      begin
        bus.hit = 1'b0;
      end
    endcase
  end

  mode_upper_a: assert property (@(posedge clk) disable iff (rst)
    mode_word[31:2] == 30'h0)
    else $error("upper mode bits not zero");

  rotary_once_a: assert property (@(posedge clk) disable iff (rst)
    rotary_taken && $past(rotary_taken) |-> $stable(rotary_value))
    else $error("rotary value changed after restart");

  mode_select_a: assert property (@(posedge clk) disable iff (rst)
    current_select == mode_word[1:0])
    else $error("current select does not follow mode word");

  value_track_a: assert property (@(posedge clk) disable iff (rst)
    sample_valid |=> value_one == $past(sample_one) && value_two == $past(sample_two))
    else $error("analog reading not updated");

endmodule : analog_input_bank

// ### core/drive_config_analog_inputs.sv
// module: top of the drive configuration and analog input object bank
`timescale 1ns/100ps

module drive_config_analog_inputs
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [15:0] OBJ_INDEX,
  input  wire logic [7:0]  OBJ_SUBINDEX,
  input  wire logic        OBJ_WR,
  input  wire logic        OBJ_RD,
  input  wire logic [31:0] OBJ_WDATA,
  output logic [31:0]      OBJ_RDATA,
  output logic             OBJ_ACK,
  output logic             OBJ_ERR,
  input  wire logic [15:0] ADC_ONE,
  input  wire logic [15:0] ADC_TWO,
  input  wire logic        ADC_VALID,
  input  wire logic [15:0] ROTARY_SWITCH,
  output logic             INPUT_ONE_CURRENT_SELECT,
  output logic             INPUT_TWO_CURRENT_SELECT,
  output logic [2:0]       FIELD_DIRECTION,
  input  wire logic        AUTO_SETUP_START,
  output logic             AUTO_SETUP_DETECT_MOTOR,
  output logic             AUTO_SETUP_LOAD_PRESET,
  output logic             AUTO_SETUP_KEEP_GAINS
);

  // ------------------------------------------------------------
  // object access fan-out
  // ------------------------------------------------------------
  obj_access_if flag_bus ();
  obj_access_if analog_bus ();

  logic [7:0]  field_inv_active;
  logic [7:0]  keep_gains;
  logic [1:0]  current_select;
  logic        access;
  logic        read_only_hit;
  logic [31:0] next_rdata;
  logic        next_ack;
  logic        next_err;
  logic        keep_latched;
  logic        next_keep_latched;
  drive_cfg_pkg::field_dir_e field_dir;

  assign access = OBJ_WR | OBJ_RD;

  // writes to read-only entries are refused with an error answer
  assign read_only_hit = (OBJ_INDEX == drive_cfg_pkg::IDX_ANALOG_VALUES) ||
                         (OBJ_INDEX == drive_cfg_pkg::IDX_ROTARY) ||
                         (OBJ_SUBINDEX == drive_cfg_pkg::SUB_COUNT &&
                          OBJ_INDEX == drive_cfg_pkg::IDX_DRIVE_FLAGS);

  assign flag_bus.index      = OBJ_INDEX;
  assign flag_bus.subindex   = OBJ_SUBINDEX;
  assign flag_bus.wr         = OBJ_WR & ~OBJ_RD;
  assign flag_bus.wdata      = OBJ_WDATA;
  assign analog_bus.index    = OBJ_INDEX;
  assign analog_bus.subindex = OBJ_SUBINDEX;
  assign analog_bus.wr       = OBJ_WR & ~OBJ_RD & ~read_only_hit;
  assign analog_bus.wdata    = OBJ_WDATA;

  drive_flag_bank u_flags
  (
    .clk              (CLK_SYS),
    .rst              (RST),
    .bus              (flag_bus),
    .field_inv_active (field_inv_active),
    .keep_gains       (keep_gains)
  );

  analog_input_bank u_analog
  (
    .clk            (CLK_SYS),
    .rst            (RST),
    .bus            (analog_bus),
    .sample_one     (ADC_ONE),
    .sample_two     (ADC_TWO),
    .sample_valid   (ADC_VALID),
    .rotary_pins    (ROTARY_SWITCH),
    .current_select (current_select)
  );

  // ------------------------------------------------------------
  // answer register
  // ------------------------------------------------------------
  always_comb
  begin
    next_rdata = OBJ_RDATA;
    next_ack   = 1'b0;
    next_err   = 1'b0;
    if (access)
    begin
      next_ack = 1'b1;
      if (OBJ_WR && OBJ_RD)
      begin
        next_err = 1'b1;
      end
      else if (flag_bus.hit)
      begin
        next_err   = OBJ_WR && read_only_hit;
        next_rdata = OBJ_RD ? flag_bus.rdata : OBJ_RDATA;
      end
      else if (analog_bus.hit)
      begin
        next_err   = OBJ_WR && read_only_hit;
        next_rdata = OBJ_RD ? analog_bus.rdata : OBJ_RDATA;
      end
      else
      begin
        next_err   = 1'b1;
        next_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      OBJ_RDATA <= 32'h0000_0000;
      OBJ_ACK   <= 1'b0;
      OBJ_ERR   <= 1'b0;
    end
    else
    begin
      OBJ_RDATA <= next_rdata;
      OBJ_ACK   <= next_ack;
      OBJ_ERR   <= next_err;
    end
  end

  // ------------------------------------------------------------
  // field direction and auto setup steering
  // ------------------------------------------------------------
  always_comb
  begin
    case (field_inv_active)
      drive_cfg_pkg::FIELD_POSITIVE: field_dir = drive_cfg_pkg::DIR_POSITIVE;
      drive_cfg_pkg::FIELD_NEGATIVE: field_dir = drive_cfg_pkg::DIR_NEGATIVE;
      default:                       field_dir = drive_cfg_pkg::DIR_FIRMWARE;
    endcase
  end

  // gains choice frozen at the start so a mid-run write cannot split the setup
  always_comb
  begin
    next_keep_latched = keep_latched;
    if (AUTO_SETUP_START)
    begin
      next_keep_latched = (keep_gains == drive_cfg_pkg::GAINS_KEEP);
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      FIELD_DIRECTION <= drive_cfg_pkg::DIR_FIRMWARE;
      keep_latched    <= 1'b0;
    end
    else
    begin
      FIELD_DIRECTION <= field_dir;
      keep_latched    <= next_keep_latched;
    end
  end

  assign AUTO_SETUP_KEEP_GAINS    = keep_latched;
  assign AUTO_SETUP_DETECT_MOTOR  = ~keep_latched;
  assign AUTO_SETUP_LOAD_PRESET   = ~keep_latched;
  // readings are raw digits; 1024 digits span 10 V or 20 mA per mode
  assign INPUT_ONE_CURRENT_SELECT = current_select[0];
  assign INPUT_TWO_CURRENT_SELECT = current_select[1];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  field_pos_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    field_inv_active == drive_cfg_pkg::FIELD_POSITIVE |=> FIELD_DIRECTION == drive_cfg_pkg::DIR_POSITIVE)
    else $error("positive field not forced");

  field_neg_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    field_inv_active == drive_cfg_pkg::FIELD_NEGATIVE |=> FIELD_DIRECTION == drive_cfg_pkg::DIR_NEGATIVE)
    else $error("negative field not forced");

  field_dflt_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    field_inv_active == drive_cfg_pkg::FIELD_DEFAULT |=> FIELD_DIRECTION == drive_cfg_pkg::DIR_FIRMWARE)
    else $error("default field not used");

  keep_gains_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    AUTO_SETUP_START && keep_gains == drive_cfg_pkg::GAINS_KEEP |=> AUTO_SETUP_KEEP_GAINS && !AUTO_SETUP_LOAD_PRESET)
    else $error("stored gains not kept");

  detect_motor_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    AUTO_SETUP_START && keep_gains == 8'h00 |=> AUTO_SETUP_DETECT_MOTOR)
    else $error("motor detection not requested");

  flag_rdback_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    OBJ_WR && !OBJ_RD && OBJ_INDEX == drive_cfg_pkg::IDX_DRIVE_FLAGS && OBJ_SUBINDEX == drive_cfg_pkg::SUB_KEEP_GAINS
    |=> keep_gains == $past(OBJ_WDATA[7:0]))
    else $error("keep-gains write lost");

  answer_one_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    access |=> OBJ_ACK ##1 (!OBJ_ACK || $past(access)))
    else $error("answer not one cycle per access");

  mode_pins_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    OBJ_WR && !OBJ_RD && OBJ_INDEX == drive_cfg_pkg::IDX_ANALOG_MODE && OBJ_SUBINDEX == drive_cfg_pkg::SUB_COUNT
    |=> {INPUT_TWO_CURRENT_SELECT, INPUT_ONE_CURRENT_SELECT} == $past(OBJ_WDATA[1:0]))
    else $error("input mode pins not following write");

  ro_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    OBJ_WR && read_only_hit |=> OBJ_ACK && OBJ_ERR)
    else $error("write to read-only entry accepted");

  unmapped_err_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    access && !(OBJ_WR && OBJ_RD) && !flag_bus.hit && !analog_bus.hit
    |=> OBJ_ERR && OBJ_RDATA == 32'h0000_0000)
    else $error("unmapped entry not refused");

endmodule : drive_config_analog_inputs

// ### test/fieldbus_host_model.sv
// partner: fieldbus host issuing object reads and writes from a request queue
`timescale 1ns/100ps
module fieldbus_host_model
(
  input  wire logic   clk,
  output logic [15:0] obj_index,
  output logic [7:0]  obj_subindex,
  output logic        obj_wr,
  output logic        obj_rd,
  output logic [31:0] obj_wdata
);
  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } req_s;

  req_s pending[$];
  req_s cur_req;

  function automatic void push(input logic wr, input logic rd, input logic [15:0] index,
                               input logic [7:0] subindex, input logic [31:0] wdata);
    pending.push_back('{wr, rd, index, subindex, wdata});
  endfunction : push

  initial
  begin
    obj_index    = 16'h0000;
    obj_subindex = 8'h00;
    obj_wr       = 1'b0;
    obj_rd       = 1'b0;
    obj_wdata    = 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // one request a cycle
  // ------------------------------------------------------------
  // idle index, subindex and data lines are inverted each cycle so a stale index never passes for a live one
  always @(negedge clk)
  begin
    if (pending.size() > 0)
    begin
      cur_req      = pending.pop_front();
      obj_wr       = cur_req.wr;
      obj_rd       = cur_req.rd;
      obj_index    = cur_req.index;
      obj_subindex = cur_req.subindex;
      obj_wdata    = cur_req.wdata;
    end
    else
    begin
      obj_wr       = 1'b0;
      obj_rd       = 1'b0;
      obj_index    = ~obj_index;
      obj_subindex = ~obj_subindex;
      obj_wdata    = ~obj_wdata;
    end
  end
endmodule : fieldbus_host_model

// ### test/drive_config_analog_inputs_tb.sv
// testbench: object access, analog readings, restart latching and auto setup choice
`timescale 1ns/100ps
`define CHECK(got, want) chk(32'(got), 32'(want))
module drive_config_analog_inputs_tb;
  typedef struct packed
  {
    logic        err;
    logic        chk;
    logic [31:0] data;
  } exp_s;

  logic        clk_sys, rst, adc_valid, start, obj_wr, obj_rd, obj_ack, obj_err;
  logic        one_sel, two_sel, detect, preset, keep;
  logic [15:0] adc_one, adc_two, rotary_switch, rotary, obj_index, a1, a2, lfsr;
  logic [7:0]  obj_subindex;
  logic [31:0] obj_wdata, obj_rdata, mode;
  logic [2:0]  field_direction, prev_dir;
  logic [7:0]  inv_val [4] = '{8'h01, 8'hFF, 8'h00, 8'h05};
  logic [2:0]  inv_dir [4] = '{drive_cfg_pkg::DIR_POSITIVE, drive_cfg_pkg::DIR_NEGATIVE,
                               drive_cfg_pkg::DIR_FIRMWARE, drive_cfg_pkg::DIR_FIRMWARE};
  int          bad_count = 0;
  int          n_compared = 0;
  exp_s        exp_q[$];
  exp_s        cur_exp;

  fieldbus_host_model fieldbus_host_model_inst
  (
    .clk(clk_sys), .obj_index(obj_index), .obj_subindex(obj_subindex), .obj_wr(obj_wr),
    .obj_rd(obj_rd), .obj_wdata(obj_wdata)
  );

  drive_config_analog_inputs drive_config_analog_inputs_inst
  (
    .CLK_SYS(clk_sys), .RST(rst), .OBJ_INDEX(obj_index), .OBJ_SUBINDEX(obj_subindex),
    .OBJ_WR(obj_wr), .OBJ_RD(obj_rd), .OBJ_WDATA(obj_wdata), .OBJ_RDATA(obj_rdata),
    .OBJ_ACK(obj_ack), .OBJ_ERR(obj_err), .ADC_ONE(adc_one), .ADC_TWO(adc_two),
    .ADC_VALID(adc_valid), .ROTARY_SWITCH(rotary_switch), .INPUT_ONE_CURRENT_SELECT(one_sel),
    .INPUT_TWO_CURRENT_SELECT(two_sel), .FIELD_DIRECTION(field_direction),
    .AUTO_SETUP_START(start), .AUTO_SETUP_DETECT_MOTOR(detect),
    .AUTO_SETUP_LOAD_PRESET(preset), .AUTO_SETUP_KEEP_GAINS(keep)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] want, input logic err);
    fieldbus_host_model_inst.push(1'b0, 1'b1, idx, sub, 32'h0000_0000);
    exp_q.push_back('{err, 1'b1, want});
  endtask : rd

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] data, input logic err);
    fieldbus_host_model_inst.push(1'b1, 1'b0, idx, sub, data);
    exp_q.push_back('{err, 1'b0, 32'h0000_0000});
  endtask : wr

  // bounded wait until every queued access has been answered
  task automatic drain();
    int n;
    n = 0;
    while ((fieldbus_host_model_inst.pending.size() > 0 || exp_q.size() > 0) && n < 40)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (exp_q.size() > 0)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, 32'h0, exp_q.size());
      exp_q.delete();
    end
    @(negedge clk_sys);
  endtask : drain

  task automatic restart();
    @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : restart

  task automatic pulse_start();
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    @(negedge clk_sys);
  endtask : pulse_start

  task automatic close_out();
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // ------------------------------------------------------------
  // answer monitor
  // ------------------------------------------------------------
  always @(negedge clk_sys)
  begin
    if (obj_ack === 1'b1)
    begin
      if (exp_q.size() == 0)
        `CHECK(obj_ack, 1'b0);
      else
      begin
        cur_exp = exp_q.pop_front();
        `CHECK(obj_err, cur_exp.err);
        if (cur_exp.chk)
          `CHECK(obj_rdata, cur_exp.data);
      end
    end
  end

  initial
  begin
    repeat (4000) @(posedge clk_sys);
    bad_count++;
    close_out();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    adc_valid = 1'b0;
    adc_one = 16'h0000;
    adc_two = 16'h0000;
    lfsr = 16'h5632;
    rotary = rnd();
    rotary_switch = rotary;
    prev_dir = drive_cfg_pkg::DIR_FIRMWARE;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    rotary_switch = ~rotary;
    rd(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_COUNT, 32'h0000_0003, 1'b0);
    rd(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_FIELD_INV, 32'h0000_0000, 1'b0);
    rd(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_KEEP_GAINS, 32'h0000_0000, 1'b0);
    rd(drive_cfg_pkg::IDX_ANALOG_VALUES, drive_cfg_pkg::SUB_INPUT_ONE, 32'h0000_0000, 1'b0);
    rd(drive_cfg_pkg::IDX_ANALOG_VALUES, drive_cfg_pkg::SUB_INPUT_TWO, 32'h0000_0000, 1'b0);
    rd(drive_cfg_pkg::IDX_ANALOG_MODE, 8'h00, 32'h0000_0000, 1'b0);
    rd(drive_cfg_pkg::IDX_ROTARY, drive_cfg_pkg::SUB_ROTARY, {16'h0000, rotary}, 1'b0);
    wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_COUNT, 32'h0000_0007, 1'b1);
    wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_FLAGS_RSVD, 32'h0000_0080, 1'b0);
    rd(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_FLAGS_RSVD, 32'hFFFF_FF80, 1'b0);
    rd(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_COUNT, 32'h0000_0003, 1'b0);
    drain();
    `CHECK(field_direction, drive_cfg_pkg::DIR_FIRMWARE);
    `CHECK({keep, detect, preset}, 3'b011);
    pulse_start();
    `CHECK({keep, detect, preset}, 3'b011);
    for (int i = 0; i < 4; i++)
    begin
      mode = {rnd(), rnd()};
      mode[1:0] = i[1:0];
      wr(drive_cfg_pkg::IDX_ANALOG_MODE, 8'h00, mode, 1'b0);
      rd(drive_cfg_pkg::IDX_ANALOG_MODE, 8'h00, {30'h0, mode[1:0]}, 1'b0);
      drain();
      `CHECK({two_sel, one_sel}, mode[1:0]);
    end
    wr(drive_cfg_pkg::IDX_ANALOG_VALUES, drive_cfg_pkg::SUB_INPUT_ONE, 32'h0000_1234, 1'b1);
    wr(drive_cfg_pkg::IDX_ROTARY, drive_cfg_pkg::SUB_ROTARY, 32'h0000_5555, 1'b1);
    rd(16'h3230, 8'h00, 32'h0000_0000, 1'b1);
    fieldbus_host_model_inst.push(1'b1, 1'b1, drive_cfg_pkg::IDX_ANALOG_MODE, 8'h00, 32'h0000_0000);
    exp_q.push_back('{1'b1, 1'b0, 32'h0000_0000});
    rd(drive_cfg_pkg::IDX_ROTARY, drive_cfg_pkg::SUB_ROTARY, {16'h0000, rotary}, 1'b0);
    rd(drive_cfg_pkg::IDX_ANALOG_MODE, 8'h00, 32'h0000_0003, 1'b0);
    drain();
    adc_one = rnd() | 16'h8000;
    adc_two = rnd() & 16'h7FFF;
    adc_valid = 1'b1;
    a1 = adc_one;
    a2 = adc_two;
    @(negedge clk_sys);
    adc_valid = 1'b0;
    adc_one = ~a1;
    adc_two = ~a2;
    rd(drive_cfg_pkg::IDX_ANALOG_VALUES, drive_cfg_pkg::SUB_INPUT_ONE, {{16{a1[15]}}, a1}, 1'b0);
    rd(drive_cfg_pkg::IDX_ANALOG_VALUES, drive_cfg_pkg::SUB_INPUT_TWO, {{16{a2[15]}}, a2}, 1'b0);
    wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_KEEP_GAINS, 32'h0000_0001, 1'b0);
    rd(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_KEEP_GAINS, 32'h0000_0001, 1'b0);
    drain();
    `CHECK(keep, 1'b0);
    pulse_start();
    `CHECK({keep, detect, preset}, 3'b100);
    wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_KEEP_GAINS, 32'h0000_0002, 1'b0);
    drain();
    pulse_start();
    `CHECK({keep, detect, preset}, 3'b011);
    for (int i = 0; i < 4; i++)
    begin
      wr(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_FIELD_INV, {24'h0, inv_val[i]}, 1'b0);
      rd(drive_cfg_pkg::IDX_DRIVE_FLAGS, drive_cfg_pkg::SUB_FIELD_INV,
         {{24{inv_val[i][7]}}, inv_val[i]}, 1'b0);
      drain();
      `CHECK(field_direction, prev_dir);
      rotary = rnd();
      rotary_switch = rotary;
      restart();
      `CHECK(field_direction, inv_dir[i]);
      rotary_switch = ~rotary;
      rd(drive_cfg_pkg::IDX_ROTARY, drive_cfg_pkg::SUB_ROTARY, {16'h0000, rotary}, 1'b0);
      drain();
      prev_dir = inv_dir[i];
    end
    close_out();
  end
endmodule : drive_config_analog_inputs_tb
